// ==== rtl/lcs_pkg.sv ====
// Constants and types for the LCD cascade alignment block
// Operation
// - Up to sixteen drivers share one bus, told apart by pins plus address bit
// - Device index is address bit times eight plus subaddress pins two..zero
// - After reset all drivers start aligned with no alignment pulse needed
// - Alignment line is open drain: device only pulls low, pull-up releases
// - Pull alignment line at onset of the last active backplane phase
// - Sample alignment line whenever this driver is not pulling it itself
// - On a detected pull, realign frame to the first driver that pulled
// - Mixed address bits plus multiplex mode may misalign; line recovers it
package lcs_pkg;
  localparam int CLK_HZ       = 10_000_000;
  localparam int OSC_HZ       = 1970;
  localparam int OSC_DIV_CYC  = CLK_HZ / OSC_HZ;
  localparam int FRAME_TICKS  = 24;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CTRL_W       = 5;
  localparam logic [4:0] CTRL_RST   = 5'h1e;
  localparam logic [5:0] SYNC_RST   = 6'h10;
  localparam int PIN_OSC      = 3;
  localparam int PIN_ALIGN    = 4;
  localparam int PIN_CLK      = 5;
  localparam int ST_INDEX_LSB = 0;
  localparam int ST_PHASE_LSB = 4;
  localparam int ST_DRIVE     = 6;
  localparam int ST_EXTCLK    = 7;
  localparam int ST_RECNT_LSB = 8;

  typedef struct packed {
    logic       enable;
    logic       clk_master;
    logic [1:0] mode;
    logic       sa_bit;
  } lcs_ctrl_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } lcs_wr_st_t;
endpackage

// ==== rtl/lcs_cascade_sync.sv ====
// Cascade addressing and frame alignment of a multiplexed LCD driver
`timescale 1ns/1ps
module lcs_cascade_sync #(
  parameter int OSC_DIV = lcs_pkg::OSC_DIV_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        hw_subaddr_pin_0,
  input  wire logic        hw_subaddr_pin_1,
  input  wire logic        hw_subaddr_pin_2,
  input  wire logic        oscillator_select_pin,
  input  wire logic        align_in,
  output logic             align_out,
  output logic             align_oe_n,
  input  wire logic        disp_clk_in,
  output logic             disp_clk_out,
  output logic             disp_clk_oe_n,
  output logic [3:0]       device_index,
  output logic             frame_start
);
  lcs_pkg::lcs_ctrl_t  ctrl_q;
  lcs_pkg::lcs_ctrl_t  wr_ctrl;
  lcs_pkg::lcs_wr_st_t wr_st_q;
  logic [5:0]  pin_meta_q;
  logic [5:0]  pin_sync_q;
  logic        clk_prev_q;
  logic        align_prev_q;
  logic [15:0] div_q;
  logic [4:0]  cnt_q;
  logic [1:0]  phase_q;
  logic [7:0]  recnt_q;
  logic        aw_have_q;
  logic        w_have_q;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        ext_sel;
  logic        tick;
  logic [4:0]  len;
  logic        wrap;
  logic        realign;
  logic        wr_fire;
  logic        mode_chg;
  logic [4:0]  cnt_d;
  logic [1:0]  phase_d;
  logic [31:0] stat;

  // Pins are asynchronous; first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_q <= lcs_pkg::SYNC_RST;
      pin_sync_q <= lcs_pkg::SYNC_RST;
    end else if (ce) begin
      pin_meta_q <= {disp_clk_in, align_in, oscillator_select_pin,
                     hw_subaddr_pin_2, hw_subaddr_pin_1, hw_subaddr_pin_0};
      pin_sync_q <= pin_meta_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_prev_q   <= 1'b0;
      align_prev_q <= 1'b1;
    end else if (ce) begin
      clk_prev_q   <= pin_sync_q[lcs_pkg::PIN_CLK];
      align_prev_q <= pin_sync_q[lcs_pkg::PIN_ALIGN];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      device_index <= 4'h0;
    end else if (ce) begin
      device_index <= {ctrl_q.sa_bit, pin_sync_q[2:0]};
    end
  end

  // Strapped external clock overrides the master bit
  assign ext_sel = pin_sync_q[lcs_pkg::PIN_OSC] | ~ctrl_q.clk_master;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 16'h0000;
    end else if (ce) begin
      if (ext_sel || div_q == 16'(OSC_DIV - 1)) begin
        div_q <= 16'h0000;
      end else begin
        div_q <= div_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      disp_clk_out  <= 1'b0;
      disp_clk_oe_n <= 1'b1;
    end else if (ce) begin
      disp_clk_out  <= !ext_sel && (div_q < 16'(OSC_DIV / 2));
      disp_clk_oe_n <= ext_sel;
    end
  end

  // Slaves count rising edges of the received clock only
  assign tick = ext_sel ? (pin_sync_q[lcs_pkg::PIN_CLK] & ~clk_prev_q)
                        : (div_q == 16'(OSC_DIV - 1));

  assign len  = 5'(lcs_pkg::FRAME_TICKS / (int'(ctrl_q.mode) + 1));
  assign wrap = tick && cnt_q == len - 5'h01;

  // Only a fall seen while released counts; own release never looks like one
  assign realign = ctrl_q.enable && align_oe_n
                   && align_prev_q
                   && !pin_sync_q[lcs_pkg::PIN_ALIGN];

  assign wr_fire  = wr_st_q == lcs_pkg::WR_IDLE && aw_have_q && w_have_q
                    && aw_addr_q == lcs_pkg::ADDR_CTRL && w_strb_q[0];
  assign wr_ctrl  = lcs_pkg::lcs_ctrl_t'(w_data_q[lcs_pkg::CTRL_W-1:0]);
  assign mode_chg = wr_fire && wr_ctrl.mode != ctrl_q.mode;

  always_comb begin
    cnt_d   = cnt_q;
    phase_d = phase_q;
    if (!ctrl_q.enable || mode_chg) begin
      cnt_d   = 5'h00;
      phase_d = 2'h0;
    end else if (realign) begin
      cnt_d   = 5'h00;
      phase_d = ctrl_q.mode;
    end else if (wrap) begin
      cnt_d   = 5'h00;
      phase_d = (phase_q == ctrl_q.mode) ? 2'h0 : phase_q + 2'h1;
    end else if (tick) begin
      cnt_d   = cnt_q + 5'h01;
    end
  end

  // Reset state is identical in every driver, so no pulse is needed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q   <= 5'h00;
      phase_q <= 2'h0;
    end else if (ce) begin
      cnt_q   <= cnt_d;
      phase_q <= phase_d;
    end
  end

  // Pull for the first tick of the last phase so static mode still releases
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      align_oe_n <= 1'b1;
      align_out  <= 1'b0;
    end else if (ce) begin
      align_oe_n <= !(ctrl_q.enable && !mode_chg && phase_d == ctrl_q.mode
                      && cnt_d == 5'h00);
      align_out  <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_start <= 1'b0;
      recnt_q     <= 8'h00;
    end else if (ce) begin
      frame_start <= ctrl_q.enable && wrap && !realign
                     && !mode_chg && phase_q == ctrl_q.mode;
      if (realign && recnt_q != 8'hff) begin
        recnt_q <= recnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= lcs_pkg::CTRL_RST;
    end else if (ce && wr_fire) begin
      ctrl_q <= lcs_pkg::lcs_ctrl_t'(w_data_q[lcs_pkg::CTRL_W-1:0]);
    end
  end

  // Write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_st_q   <= lcs_pkg::WR_IDLE;
      awready   <= 1'b1;
      wready    <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= lcs_pkg::RESP_OKAY;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= awaddr;
        awready   <= 1'b0;
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
        wready   <= 1'b0;
      end
      case (wr_st_q)
        lcs_pkg::WR_IDLE: begin
          if (aw_have_q && w_have_q) begin
            wr_st_q   <= lcs_pkg::WR_RESP;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            bvalid    <= 1'b1;
            bresp     <= (aw_addr_q == lcs_pkg::ADDR_CTRL
                          || aw_addr_q == lcs_pkg::ADDR_STAT)
                         ? lcs_pkg::RESP_OKAY : lcs_pkg::RESP_SLVERR;
          end
        end
        lcs_pkg::WR_RESP: begin
          if (bready) begin
            wr_st_q <= lcs_pkg::WR_IDLE;
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
          end
        end
        default: wr_st_q <= lcs_pkg::WR_IDLE;
      endcase
    end
  end

  always_comb begin
    stat = 32'h0000_0000;
    stat[lcs_pkg::ST_INDEX_LSB +: 4] = device_index;
    stat[lcs_pkg::ST_PHASE_LSB +: 2] = phase_q;
    stat[lcs_pkg::ST_DRIVE]          = !align_oe_n;
    stat[lcs_pkg::ST_EXTCLK]         = ext_sel;
    stat[lcs_pkg::ST_RECNT_LSB +: 8] = recnt_q;
  end

  // Read channel: one read at a time, answer one edge after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= lcs_pkg::RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rresp   <= lcs_pkg::RESP_OKAY;
        case (araddr)
          lcs_pkg::ADDR_CTRL: rdata <= {27'h000_0000, ctrl_q};
          lcs_pkg::ADDR_STAT: rdata <= stat;
          default: begin
            rdata <= 32'h0000_0000;
            rresp <= lcs_pkg::RESP_SLVERR;
          end
        endcase
      end else if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  default clocking cb_main @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence seq_last_onset;
    ce && ctrl_q.enable && !mode_chg && !realign && tick
      && cnt_q == len - 5'h01
      && phase_q + 2'h1 == ctrl_q.mode;
  endsequence

  sequence seq_line_fall;
    ce && realign;
  endsequence

  a_index_compose: assert property (
    ce |=> device_index == {$past(ctrl_q.sa_bit), $past(pin_sync_q[2:0])})
    else $error("device index not address bit plus pins");

  a_reset_quiet: assert property (
    $rose(aresetn) |-> align_oe_n && phase_q == 2'h0 && cnt_q == 5'h00)
    else $error("not in common start state after reset");

  a_open_drain: assert property (
    !align_oe_n |-> !align_out && phase_q == ctrl_q.mode)
    else $error("alignment line driven high or off last phase");

  a_onset_pull: assert property (
    seq_last_onset |=> !align_oe_n && cnt_q == 5'h00)
    else $error("no pull at last phase onset");

  // A realign during an own pull would be invisible but for the count
  a_no_self_sample: assert property (
    ce && !align_oe_n |=> $stable(recnt_q))
    else $error("realign counted on own pull");

  a_realign_jump: assert property (
    seq_line_fall and !mode_chg |=> phase_q == $past(ctrl_q.mode)
    && cnt_q == 5'h00 && !align_oe_n)
    else $error("realign did not jump to last phase");

  a_mode_restart: assert property (
    ce && mode_chg |=> phase_q == 2'h0 && cnt_q == 5'h00 && align_oe_n)
    else $error("mode change did not restart frame");

  a_slave_osc_off: assert property (
    ce && ext_sel ##1 ce && ext_sel |-> div_q == 16'h0000
    && disp_clk_oe_n && !disp_clk_out)
    else $error("oscillator runs while clock slave");
endmodule

// ==== verif/lcs_peer_model.sv ====
// Model of another cascaded driver sharing the alignment line and clock
`timescale 1ns/1ps
module lcs_peer_model #(
  parameter int HALF = 20
) (
  input  wire logic aclk,
  input  wire logic clk_en,
  input  wire logic pull,
  output logic      align_oe_n,
  output logic      disp_clk
);
  int cnt = 0;
  initial align_oe_n = 1'b1;
  initial disp_clk = 1'b0;
  // Only ever pulls low; the pull-up restores the line
  always @(posedge aclk) align_oe_n <= ~pull;
  // Clock stands still low while this peer is not the clock source
  always @(posedge aclk) begin
    if (!clk_en) begin
      cnt      <= 0;
      disp_clk <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt      <= 0;
      disp_clk <= ~disp_clk;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// ==== verif/lcs_cascade_sync_tb_top.sv ====
// Self-checking testbench of the LCD cascade alignment block
`timescale 1ns/1ps
module lcs_cascade_sync_tb_top;
  logic        aclk = 0, aresetn = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [2:0]  pins = 0;
  logic        osc = 0, pull = 0, peer_en = 0;
  logic        a_out, a_oe_n, p_oe_n, c_out, c_oe_n, p_clk, fs;
  logic [3:0]  idx, i;
  logic [65:0] exp_q[$], q_m;
  int          failures = 0, comparisons = 0, cnt, base;
  wire         align_w = a_oe_n & p_oe_n;
  wire         clk_w = c_oe_n ? p_clk : c_out;
  always #50 aclk = ~aclk;
  lcs_cascade_sync #(.OSC_DIV(20)) u_lcs_cascade_sync (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .hw_subaddr_pin_0(pins[0]), .hw_subaddr_pin_1(pins[1]),
    .hw_subaddr_pin_2(pins[2]), .oscillator_select_pin(osc),
    .align_in(align_w), .align_out(a_out), .align_oe_n(a_oe_n),
    .disp_clk_in(clk_w), .disp_clk_out(c_out), .disp_clk_oe_n(c_oe_n),
    .device_index(idx), .frame_start(fs));
  lcs_peer_model #(.HALF(20)) u_lcs_peer_model (.aclk(aclk),
    .clk_en(peer_en), .pull(pull), .align_oe_n(p_oe_n), .disp_clk(p_clk));
  task check(input logic [33:0] seen, input logic [33:0] expd);
    comparisons++;
    if (seen !== expd) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expd);
    end
  endtask
  task results;
    if (failures == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge aclk); while (!bvalid);
    check(bresp, r);
    bready <= 0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
          input logic [1:0] r);
    exp_q.push_back({r, m, e});
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    while (!rvalid) @(posedge aclk);
    rready <= 0;
  endtask
  // Read results are judged against the oldest note of the driver
  always @(posedge aclk) if (rvalid && rready) begin
    q_m = exp_q.pop_front();
    check({rresp, rdata & q_m[63:32]}, {q_m[65:64], q_m[31:0]});
  end
  task frame(input int per);
    cnt = 0;
    while (!fs && cnt < 3000) begin @(posedge aclk); cnt++; end
    cnt = 0;
    do begin @(posedge aclk); cnt++; end while (!fs && cnt < 3000);
    check(cnt, per);
  endtask
  initial begin
    base = $urandom(61118);
    pins <= base[2:0];
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    rd(lcs_pkg::ADDR_CTRL, 32'h0000_001f, 32'h0000_001e, 2'h0);
    frame(480);
    check(c_oe_n, 1'b0);
    rd(lcs_pkg::ADDR_STAT, 32'h0000_ff80, 32'h0000_0000, 2'h0);
    rd(12'h008, 32'hffff_ffff, 32'h0000_0000, lcs_pkg::RESP_SLVERR);
    wr(12'h00c, 32'h0000_0000, lcs_pkg::RESP_SLVERR);
    wr(lcs_pkg::ADDR_STAT, 32'h0000_0000, lcs_pkg::RESP_OKAY);
    rd(lcs_pkg::ADDR_CTRL, 32'h0000_001f, 32'h0000_001e, 2'h0);
    for (int k = 0; k < 16; k++) begin
      i = 4'(base + k);
      pins <= i[2:0];
      wr(lcs_pkg::ADDR_CTRL, 32'h0000_001e | 32'(i[3]), 2'h0);
      repeat (3) @(posedge aclk);
      check(idx, i);
      rd(lcs_pkg::ADDR_STAT, 32'h0000_000f, 32'(i), 2'h0);
    end
    for (int m = 0; m < 4; m++) begin
      wr(lcs_pkg::ADDR_CTRL, 32'h0000_0018 | 32'(m << 1), 2'h0);
      // Static mode pulls right after a restart, off the tick grid
      cnt = 0;
      while (!fs && cnt < 3000) begin @(posedge aclk); cnt++; end
      while (a_oe_n && cnt < 3000) begin @(posedge aclk); cnt++; end
      rd(lcs_pkg::ADDR_STAT, 32'h0000_0070, 32'(m << 4) | 32'h40,
         2'h0);
    end
    // Mixed address bits; a peer pull two edges after a frame start must be joined
    for (int r = 1; r < 3; r++) begin
      wr(lcs_pkg::ADDR_CTRL, 32'h0000_001e | 32'(r & 1), 2'h0);
      frame(480);
      repeat (2) @(posedge aclk);
      pull <= 1;
      repeat (6) @(posedge aclk);
      check(a_oe_n, 1'b0);
      check(a_out, 1'b0);
      pull <= 0;
      rd(lcs_pkg::ADDR_STAT, 32'h0000_ff70, 32'(r << 8) | 32'h70,
         2'h0);
    end
    peer_en <= 1;
    for (int c = 0; c < 2; c++) begin
      osc <= c[0];
      wr(lcs_pkg::ADDR_CTRL, c ? 32'h0000_001e : 32'h0000_0016, 2'h0);
      repeat (3) @(posedge aclk);
      check({c_oe_n, c_out}, 2'b10);
      rd(lcs_pkg::ADDR_STAT, 32'h0000_0080, 32'h0000_0080, 2'h0);
      frame(960);
    end
    results();
  end
  initial begin
    #5_000_000;
    failures++;
    results();
  end
endmodule
